// [logic/mvkd_defines.svh]
// constants for the verify and key derive command block
`ifndef MVKD_DEFINES_SVH
`define MVKD_DEFINES_SVH
`define OPC_VERIFY      8'h28
`define OPC_DERIVE      8'h1C
`define MODE_CHAL_SCR   0
`define MODE_KEY_SCR    1
`define MODE_ORIGIN     2
`define MODE_OTP        5
`define MODE_COPY       8'h01
`define POL_LIMITED     4
`define POL_CREATE      12
`define POL_DERIVE_EN   13
`define POL_MAC_REQ     15
`define USE_FLAG_FULL   8'hFF
`define USE_FLAG_EMPTY  8'h00
`define CNT_RESET       8'h00
`define RSP_OK          8'h00
`define RSP_MISMATCH    8'h01
`define RSP_ERR         8'h0F
`define LEN_VERIFY      7'h58
`define LEN_MAC         7'h27
`define LEN_DERIVE      7'h60
`endif

// [logic/mvkd_pkg.sv]
// types for the verify and key derive command block
package mvkd_pkg;
  typedef struct packed {
    logic [7:0]        opcode;
    logic [7:0]        p1;
    logic [15:0]       p2;
    logic [0:76][7:0]  data;   // byte 0 first on the wire
  } cmd_s;
  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_CHECK = 7'b0000010,
    S_BUILD = 7'b0000100,
    S_SEND  = 7'b0001000,
    S_WAIT  = 7'b0010000,
    S_COPY  = 7'b0100000,
    S_RESP  = 7'b1000000
  } state_e;
  typedef enum logic [2:0] {
    PH_VER = 3'b001,
    PH_MAC = 3'b010,
    PH_DER = 3'b100
  } phase_e;
endpackage : mvkd_pkg

// [logic/mac_verify_key_derive.sv]
// command engine for peer MAC verify and stored key derive
`timescale 1ns/10ps
`include "mvkd_defines.svh"
module mac_verify_key_derive (
  input  wire logic                MCLK_IN,          // 200 MHz clock
  input  wire logic                RST_IN,           // sync reset, active high
  input  wire logic                CMD_VALID_IN,     // command offered
  output logic                     CMD_READY_OUT,    // engine idle
  input  wire mvkd_pkg::cmd_s      CMD_IN,           // opcode, params, data
  input  wire logic                SCR_LOAD_IN,      // nonce logic loads scratch
  input  wire logic [255:0]        SCR_VALUE_IN,     // value to load
  input  wire logic                SCR_ORIGIN_IN,    // origin of loaded value
  input  wire logic                IDLE_IN,          // device enters idle
  input  wire logic [15:0][15:0]   SLOT_POLICY_IN,   // policy word per slot
  output logic [3:0]               KEY_IDX_OUT,      // key slot read/write
  input  wire logic [255:0]        KEY_DATA_IN,      // key at KEY_IDX_OUT
  output logic                     KEY_WR_OUT,       // key write pulse
  output logic [255:0]             KEY_WR_DATA_OUT,  // key to store
  input  wire logic [0:7][7:0]     OTP_IN,           // first 64 OTP bits
  input  wire logic [0:8][7:0]     SERIAL_IN,        // device serial
  output logic [7:0]               HASH_BYTE_OUT,    // message byte
  output logic                     HASH_VALID_OUT,   // byte valid
  output logic                     HASH_LAST_OUT,    // last byte of message
  input  wire logic                HASH_READY_IN,    // hash takes byte
  input  wire logic                HASH_DONE_IN,     // digest ready pulse
  input  wire logic [255:0]        HASH_DIGEST_IN,   // digest
  output logic                     RSP_VALID_OUT,    // answer pulse
  output logic                     RSP_ERR_OUT,      // answer is error
  output logic [7:0]               RSP_BYTE_OUT,     // answer byte
  output logic                     SCR_VALID_OUT,    // scratch valid
  output logic                     SCR_ORIGIN_OUT,   // scratch origin flag
  output logic [7:0][7:0]          USE_FLAG_OUT,     // use flags slots 0-7
  output logic [7:0][7:0]          REWRITE_CNT_OUT   // counters slots 0-7
);
  mvkd_pkg::state_e  state_ff;
  mvkd_pkg::phase_e  phase_ff;
  mvkd_pkg::cmd_s    cmd_ff;
  logic [767:0]      msg_ff;
  logic [6:0]        len_ff;
  logic [6:0]        cnt_ff;
  logic [3:0]        key_idx_ff;
  logic              key_wr_ff;
  logic [255:0]      key_wr_data_ff;
  logic [255:0]      scr_value_ff;
  logic              scr_valid_ff;
  logic              scr_origin_ff;
  logic              scr_copied_ff;
  logic              cmd_scr_ok_ff;
  logic              rsp_valid_ff;
  logic              rsp_err_ff;
  logic [7:0]        rsp_byte_ff;
  logic [7:0][7:0]   use_flag_ff;
  logic [7:0][7:0]   cnt_slot_ff;
  // decoded view of the latched command
  logic              is_verify;
  logic              is_derive;
  logic [7:0]        mode;
  logic [3:0]        dest;
  logic [15:0]       dpol;
  logic [3:0]        parent;
  logic [15:0]       ppol;
  logic [3:0]        copy_slot;
  logic [3:0]        src_slot;
  logic              origin_bad;
  logic              parent_spent;
  logic              verify_err;
  logic              derive_err;
  logic              accept;
  logic              digest_hit;
  logic [255:0]      msg_key;
  logic [255:0]      msg_chal;
  logic [63:0]       msg_otp;

  assign accept     = (state_ff == mvkd_pkg::S_IDLE) && CMD_VALID_IN;
  assign is_verify  = (cmd_ff.opcode == `OPC_VERIFY);
  assign is_derive  = (cmd_ff.opcode == `OPC_DERIVE);
  assign mode       = cmd_ff.p1;
  assign dest       = cmd_ff.p2[3:0];
  assign dpol       = SLOT_POLICY_IN[dest];
  assign parent     = dpol[11:8];
  assign ppol       = SLOT_POLICY_IN[parent];
  // even index pairs with the next slot, odd index is its own target
  assign copy_slot  = dest[0] ? dest : dest + 4'h1;
  assign src_slot   = dpol[`POL_CREATE] ? parent : dest;
  assign origin_bad = (mode[`MODE_ORIGIN] != scr_origin_ff) || !cmd_scr_ok_ff;
  // only slots 0-7 keep use flags, higher parents never run out
  assign parent_spent = ppol[`POL_LIMITED] && !parent[3] &&
                        (use_flag_ff[parent[2:0]] == `USE_FLAG_EMPTY);
  assign verify_err = (mode[`MODE_CHAL_SCR] || mode[`MODE_KEY_SCR]) && origin_bad;
  // destination use state is never looked at, only the parent's
  assign derive_err = origin_bad || !dpol[`POL_DERIVE_EN] ||
                      ((dpol[`POL_CREATE] || dpol[`POL_MAC_REQ]) && parent_spent);
  assign digest_hit = (HASH_DIGEST_IN == ((phase_ff == mvkd_pkg::PH_MAC) ? cmd_ff.data[0:31]
                                                                          : cmd_ff.data[32:63]));

  // message sources picked by the verify mode bits
  assign msg_key  = mode[`MODE_KEY_SCR] ? scr_value_ff : KEY_DATA_IN;
  assign msg_chal = mode[`MODE_CHAL_SCR] ? scr_value_ff : cmd_ff.data[0:31];
  assign msg_otp  = mode[`MODE_OTP] ? OTP_IN : 64'h0000000000000000;

  assign CMD_READY_OUT   = (state_ff == mvkd_pkg::S_IDLE);
  assign HASH_BYTE_OUT   = msg_ff[767:760];
  assign HASH_VALID_OUT  = (state_ff == mvkd_pkg::S_SEND);
  assign HASH_LAST_OUT   = HASH_VALID_OUT && (cnt_ff == len_ff - 7'h01);
  assign KEY_IDX_OUT     = key_idx_ff;
  assign KEY_WR_OUT      = key_wr_ff;
  assign KEY_WR_DATA_OUT = key_wr_data_ff;
  assign RSP_VALID_OUT   = rsp_valid_ff;
  assign RSP_ERR_OUT     = rsp_err_ff;
  assign RSP_BYTE_OUT    = rsp_byte_ff;
  assign SCR_VALID_OUT   = scr_valid_ff;
  assign SCR_ORIGIN_OUT  = scr_origin_ff;
  assign USE_FLAG_OUT    = use_flag_ff;
  assign REWRITE_CNT_OUT = cnt_slot_ff;

  // command latch; the whole field set arrives at once
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      cmd_ff <= '0;
    end else if (accept) begin
      cmd_ff <= CMD_IN;
    end
  end

  // sequencer: check, build message, stream it, act on the digest
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      state_ff   <= mvkd_pkg::S_IDLE;
      phase_ff   <= mvkd_pkg::PH_VER;
      key_idx_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        mvkd_pkg::S_IDLE: begin
          if (accept) begin
            state_ff <= mvkd_pkg::S_CHECK;
          end
        end
        mvkd_pkg::S_CHECK: begin
          if (is_verify && !verify_err) begin
            phase_ff   <= mvkd_pkg::PH_VER;
            key_idx_ff <= dest;
            state_ff   <= mvkd_pkg::S_BUILD;
          end else if (is_derive && !derive_err) begin
            // authorisation MAC is always keyed by the parent slot
            phase_ff   <= dpol[`POL_MAC_REQ] ? mvkd_pkg::PH_MAC : mvkd_pkg::PH_DER;
            key_idx_ff <= dpol[`POL_MAC_REQ] ? parent : src_slot;
            state_ff   <= mvkd_pkg::S_BUILD;
          end else begin
            state_ff <= mvkd_pkg::S_RESP;
          end
        end
        mvkd_pkg::S_BUILD: state_ff <= mvkd_pkg::S_SEND;
        mvkd_pkg::S_SEND: begin
          if (HASH_READY_IN && HASH_LAST_OUT) begin
            state_ff <= mvkd_pkg::S_WAIT;
          end
        end
        mvkd_pkg::S_WAIT: begin
          if (HASH_DONE_IN) begin
            unique case (phase_ff)
              mvkd_pkg::PH_VER: begin
                if (digest_hit && (mode == `MODE_COPY) &&
                    (SLOT_POLICY_IN[copy_slot][3:0] == 4'h0)) begin
                  key_idx_ff <= copy_slot;
                  state_ff   <= mvkd_pkg::S_COPY;
                end else begin
                  state_ff <= mvkd_pkg::S_RESP;
                end
              end
              mvkd_pkg::PH_MAC: begin
                if (digest_hit) begin
                  phase_ff   <= mvkd_pkg::PH_DER;
                  key_idx_ff <= src_slot;
                  state_ff   <= mvkd_pkg::S_BUILD;
                end else begin
                  state_ff <= mvkd_pkg::S_RESP;
                end
              end
              mvkd_pkg::PH_DER: begin
                key_idx_ff <= dest;
                state_ff   <= mvkd_pkg::S_RESP;
              end
            endcase
          end
        end
        mvkd_pkg::S_COPY: state_ff <= mvkd_pkg::S_RESP;
        mvkd_pkg::S_RESP: state_ff <= mvkd_pkg::S_IDLE;
      endcase
    end
  end

  // message assembly and byte streaming, first byte in the top lane
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      msg_ff <= '0;
      len_ff <= 7'h00;
      cnt_ff <= 7'h00;
    end else if (state_ff == mvkd_pkg::S_BUILD) begin
      cnt_ff <= 7'h00;
      unique case (phase_ff)
        mvkd_pkg::PH_VER: begin
          msg_ff <= {msg_key, msg_chal, cmd_ff.data[64:67], msg_otp,
                     cmd_ff.data[68:70], SERIAL_IN[8], cmd_ff.data[71:74],
                     SERIAL_IN[0:1], cmd_ff.data[75:76], 64'h0000000000000000};
          len_ff <= `LEN_VERIFY;
        end
        mvkd_pkg::PH_MAC: begin
          msg_ff <= {KEY_DATA_IN, cmd_ff.opcode, cmd_ff.p1, cmd_ff.p2[7:0],
                     cmd_ff.p2[15:8], SERIAL_IN[8], SERIAL_IN[0:1], 456'h0};
          len_ff <= `LEN_MAC;
        end
        mvkd_pkg::PH_DER: begin
          msg_ff <= {KEY_DATA_IN, cmd_ff.opcode, cmd_ff.p1, cmd_ff.p2[7:0],
                     cmd_ff.p2[15:8], SERIAL_IN[8], SERIAL_IN[0:1], 200'h0,
                     scr_value_ff};
          len_ff <= `LEN_DERIVE;
        end
      endcase
    end else if (HASH_VALID_OUT && HASH_READY_IN) begin
      msg_ff <= {msg_ff[759:0], 8'h00};
      cnt_ff <= cnt_ff + 7'h01;
    end
  end

  // answer byte; decided in the check or on the digest, shown two or three cycles later
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      rsp_valid_ff <= 1'b0;
      rsp_err_ff   <= 1'b0;
      rsp_byte_ff  <= 8'h00;
    end else begin
      rsp_valid_ff <= (state_ff == mvkd_pkg::S_RESP);
      if (state_ff == mvkd_pkg::S_CHECK) begin
        rsp_err_ff  <= 1'b1;
        rsp_byte_ff <= `RSP_ERR;
      end else if ((state_ff == mvkd_pkg::S_WAIT) && HASH_DONE_IN) begin
        if (phase_ff == mvkd_pkg::PH_VER) begin
          rsp_err_ff  <= 1'b0;
          rsp_byte_ff <= digest_hit ? `RSP_OK : `RSP_MISMATCH;
        end else if (phase_ff == mvkd_pkg::PH_MAC) begin
          rsp_err_ff  <= !digest_hit;
          rsp_byte_ff <= digest_hit ? `RSP_OK : `RSP_ERR;
        end else begin
          rsp_err_ff  <= 1'b0;
          rsp_byte_ff <= `RSP_OK;
        end
      end
    end
  end

  // key store write after a derive digest
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      key_wr_ff      <= 1'b0;
      key_wr_data_ff <= '0;
    end else begin
      key_wr_ff <= (state_ff == mvkd_pkg::S_WAIT) && HASH_DONE_IN &&
                   (phase_ff == mvkd_pkg::PH_DER);
      if (HASH_DONE_IN) begin
        key_wr_data_ff <= HASH_DIGEST_IN;
      end
    end
  end

  // scratch digest; a copy wins over a load in the same cycle
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      scr_value_ff  <= '0;
      scr_valid_ff  <= 1'b0;
      scr_origin_ff <= 1'b0;
      scr_copied_ff <= 1'b0;
      cmd_scr_ok_ff <= 1'b0;
    end else begin
      if (accept) begin
        cmd_scr_ok_ff <= scr_valid_ff;
      end
      if (state_ff == mvkd_pkg::S_COPY) begin
        scr_value_ff  <= KEY_DATA_IN;
        scr_valid_ff  <= 1'b1;
        scr_copied_ff <= 1'b1;
      end else if (SCR_LOAD_IN) begin
        scr_value_ff  <= SCR_VALUE_IN;
        scr_valid_ff  <= 1'b1;
        scr_origin_ff <= SCR_ORIGIN_IN;
        scr_copied_ff <= 1'b0;
      end else if (accept) begin
        scr_valid_ff <= 1'b0;
      end else if (IDLE_IN && scr_copied_ff) begin
        scr_valid_ff  <= 1'b0;
        scr_value_ff  <= '0;
        scr_copied_ff <= 1'b0;
      end
    end
  end

  // per-slot use flag and rewrite counter, touched only on success
  generate
    for (genvar s = 0; s < 8; s++) begin : g_slot
      always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
          use_flag_ff[s] <= `USE_FLAG_FULL;
          cnt_slot_ff[s] <= `CNT_RESET;
        end else if ((state_ff == mvkd_pkg::S_WAIT) && HASH_DONE_IN &&
                     (phase_ff == mvkd_pkg::PH_DER) && (dest == 4'(s))) begin
          use_flag_ff[s] <= `USE_FLAG_FULL;
          cnt_slot_ff[s] <= cnt_slot_ff[s] + 8'h01;
        end
      end
    end
  endgenerate

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_ver_done;
    (state_ff == mvkd_pkg::S_WAIT) && (phase_ff == mvkd_pkg::PH_VER) && HASH_DONE_IN;
  endsequence
  sequence s_checking(logic cond);
    (state_ff == mvkd_pkg::S_CHECK) && cond;
  endsequence
  sequence s_err_rsp;
    ##2 (RSP_VALID_OUT && RSP_ERR_OUT && (RSP_BYTE_OUT == `RSP_ERR));
  endsequence
  property p_ver_match;
    s_ver_done ##0 digest_hit |-> ##[2:3] (RSP_VALID_OUT && (RSP_BYTE_OUT == `RSP_OK));
  endproperty
  a_ver_match: assert property (p_ver_match) else $error("verify match not zero");
  property p_ver_miss;
    s_ver_done ##0 !digest_hit |-> ##2 (RSP_VALID_OUT && (RSP_BYTE_OUT == `RSP_MISMATCH));
  endproperty
  a_ver_miss: assert property (p_ver_miss) else $error("verify miss not one");
  property p_ver_origin;
    s_checking(is_verify && (mode[1:0] != 2'b00) && (mode[2] != scr_origin_ff)) |-> s_err_rsp;
  endproperty
  a_ver_origin: assert property (p_ver_origin) else $error("verify origin ok");
  property p_der_origin;
    s_checking(is_derive && (mode[2] != scr_origin_ff)) |-> s_err_rsp;
  endproperty
  a_der_origin: assert property (p_der_origin) else $error("derive origin ok");
  property p_der_enable;
    s_checking(is_derive && !dpol[`POL_DERIVE_EN]) |-> s_err_rsp;
  endproperty
  a_der_enable: assert property (p_der_enable) else $error("derive not enabled");
  property p_counter;
    KEY_WR_OUT && !KEY_IDX_OUT[3] |->
      (REWRITE_CNT_OUT[dest[2:0]] == 8'($past(REWRITE_CNT_OUT[dest[2:0]]) + 8'h01))
      && (USE_FLAG_OUT[KEY_IDX_OUT[2:0]] == `USE_FLAG_FULL);
  endproperty
  a_counter: assert property (p_counter) else $error("counter not bumped");
  property p_der_done;
    KEY_WR_OUT |-> ##1 (RSP_VALID_OUT && !RSP_ERR_OUT && (RSP_BYTE_OUT == `RSP_OK));
  endproperty
  a_der_done: assert property (p_der_done) else $error("derive answer wrong");
  property p_err_quiet;
    RSP_VALID_OUT && RSP_ERR_OUT |-> !$past(KEY_WR_OUT, 2) && $stable(REWRITE_CNT_OUT);
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error changed state");
  property p_idle_drop;
    IDLE_IN && scr_copied_ff && !SCR_LOAD_IN && !accept &&
      (state_ff != mvkd_pkg::S_COPY) |=> !SCR_VALID_OUT;
  endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("copied scratch kept");
  property p_next_clears;
    accept && !SCR_LOAD_IN |=> !SCR_VALID_OUT;
  endproperty
  a_next_clears: assert property (p_next_clears) else $error("scratch valid kept");
endmodule : mac_verify_key_derive

// [sim/mvkd_partner.sv]
// key store and hash engine model facing the command engine
`timescale 1ns/10ps
module mvkd_partner (
  input  wire logic          clk_in,      // clock
  input  wire logic [3:0]    idx_in,      // slot addressed
  output logic [255:0]       key_out,     // key of that slot
  input  wire logic          wr_in,       // key write pulse
  input  wire logic [255:0]  wr_data_in,  // key to store
  input  wire logic [7:0]    byte_in,     // message byte
  input  wire logic          valid_in,    // byte offered
  input  wire logic          last_in,     // last byte of message
  output logic               ready_out,   // byte taken
  output logic               done_out,    // digest pulse
  output logic [255:0]       digest_out,  // digest
  input  wire logic [255:0]  dig_in       // digest the bench wants back
);
  logic [255:0] key [16];
  logic [7:0]   got [$];
  logic [7:0]   lfsr = 8'hA5;
  int           wait_n = 0;
  // store reads combinationally, as the engine expects
  assign key_out   = key[idx_in];
  // stalls follow an lfsr so the engine sees ragged ready
  assign ready_out = lfsr[0] | lfsr[1];
  // digest is only meaningful with done; otherwise show its inverse
  always @(posedge clk_in) begin
    lfsr       <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    done_out   <= (wait_n == 1);
    digest_out <= (wait_n == 1) ? dig_in : ~dig_in;
    if (wr_in)
      key[idx_in] <= wr_data_in;
    if (valid_in && ready_out) begin
      got.push_back(byte_in);
      if (last_in)
        wait_n <= 3;
    end
    if (wait_n > 0)
      wait_n <= wait_n - 1;
  end
endmodule : mvkd_partner

// [sim/testbench.sv]
// self-checking bench for the verify and key derive engine
`timescale 1ns/10ps
module testbench;
  logic clk, rst, cval, crdy, sload, sorig, idle, kwr, hval, hlast, hrdy, hdone;
  logic rval, rerr, svalid, sorg;
  mvkd_pkg::cmd_s    cmd;
  logic [255:0]      sval, kdat, kwd, hdig, dig;
  logic [15:0][15:0] pol;
  logic [3:0]        kidx;
  logic [0:7][7:0]   otp;
  logic [0:8][7:0]   sn;
  logic [7:0]        hbyte, rbyte;
  logic [7:0][7:0]   usef, cnt;
  logic [8:0]        exp_rsp [$];
  logic [7:0]        exp_msg [$];
  int                mismatches = 0;
  int                check_count = 0;
  int                seed = 87;
  mac_verify_key_derive i_mac_verify_key_derive (.MCLK_IN(clk), .RST_IN(rst),
    .CMD_VALID_IN(cval), .CMD_READY_OUT(crdy), .CMD_IN(cmd), .SCR_LOAD_IN(sload),
    .SCR_VALUE_IN(sval), .SCR_ORIGIN_IN(sorig), .IDLE_IN(idle), .SLOT_POLICY_IN(pol),
    .KEY_IDX_OUT(kidx), .KEY_DATA_IN(kdat), .KEY_WR_OUT(kwr), .KEY_WR_DATA_OUT(kwd),
    .OTP_IN(otp), .SERIAL_IN(sn), .HASH_BYTE_OUT(hbyte), .HASH_VALID_OUT(hval),
    .HASH_LAST_OUT(hlast), .HASH_READY_IN(hrdy), .HASH_DONE_IN(hdone),
    .HASH_DIGEST_IN(hdig), .RSP_VALID_OUT(rval), .RSP_ERR_OUT(rerr),
    .RSP_BYTE_OUT(rbyte), .SCR_VALID_OUT(svalid), .SCR_ORIGIN_OUT(sorg),
    .USE_FLAG_OUT(usef), .REWRITE_CNT_OUT(cnt));
  mvkd_partner i_mvkd_partner (.clk_in(clk), .idx_in(kidx), .key_out(kdat),
    .wr_in(kwr), .wr_data_in(kwd), .byte_in(hbyte), .valid_in(hval),
    .last_in(hlast), .ready_out(hrdy), .done_out(hdone), .digest_out(hdig),
    .dig_in(dig));
  // clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [255:0] g, input logic [255:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic put(input logic [7:0] b);
    exp_msg.push_back(b);
  endtask : put
  // keys and digests go out most significant byte first
  task automatic put32(input logic [255:0] v);
    for (int i = 31; i >= 0; i--) put(v[i*8+:8]);
  endtask : put32
  task automatic vmsg(input logic [255:0] k, input logic [255:0] c);
    put32(k);
    put32(c);
    for (int i = 0; i < 13; i++) begin
      if (i == 4) for (int j = 0; j < 8; j++) put(cmd.p1[5] ? otp[j] : 8'h00);
      if (i == 7) put(sn[8]);
      if (i == 11) begin
        put(sn[0]);
        put(sn[1]);
      end
      put(cmd.data[64+i]);
    end
  endtask : vmsg
  // header shared by the mac check and the derive message
  task automatic hdr(input logic [255:0] k);
    put32(k);
    put(8'h1C);
    put(cmd.p1);
    put(cmd.p2[7:0]);
    put(cmd.p2[15:8]);
    put(sn[8]);
    put(sn[0]);
    put(sn[1]);
  endtask : hdr
  task automatic dmsg(input logic [255:0] k);
    hdr(k);
    repeat (25) put(8'h00);
    put32(sval);
  endtask : dmsg
  task automatic setc(input logic [7:0] op, input logic [7:0] p1, input logic [15:0] p2);
    foreach (cmd.data[i]) cmd.data[i] = $random(seed);
    cmd.opcode = op;
    cmd.p1 = p1;
    cmd.p2 = p2;
  endtask : setc
  task automatic load(input logic o);
    sval = {$random(seed), $random(seed), 192'h0} ^ {8{$random(seed)}};
    sorig = o;
    sload = 1'b1;
    @(posedge clk);
    #1 sload = 1'b0;
  endtask : load
  task automatic pulse_idle();
    idle = 1'b1;
    @(posedge clk);
    #1 idle = 1'b0;
    @(posedge clk);
    #1;
  endtask : pulse_idle
  // one command: note the answer, offer it, wait for the answer, check the stream
  task automatic run(input logic [8:0] er, input bit msg);
    int n;
    exp_rsp.push_back(er);
    i_mvkd_partner.got.delete();
    cval = 1'b1;
    @(posedge clk);
    #1 cval = 1'b0;
    n = 0;
    while (exp_rsp.size() != 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      wrap_up();
    end
    #1;
    if (msg) begin
      chk(i_mvkd_partner.got.size(), exp_msg.size());
      foreach (exp_msg[i]) chk(i_mvkd_partner.got[i], exp_msg[i]);
    end
    exp_msg.delete();
  endtask : run
  // answer monitor takes the oldest note for every answer pulse
  always @(posedge clk) begin
    if (rval === 1'b1) begin
      chk({rerr, rbyte}, exp_rsp.size() ? exp_rsp[0] : 9'h1FF);
      if (exp_rsp.size() != 0) void'(exp_rsp.pop_front());
    end
  end
  // watchdog sized well above the longest run of derives
  initial begin
    #450000;
    mismatches++;
    wrap_up();
  end
  initial begin
    cval = 1'b0; sload = 1'b0; sorig = 1'b0; idle = 1'b0; rst = 1'b1;
    sval = '0; cmd = '0; pol = '0;
    dig = {8{$random(seed)}};
    for (int i = 0; i < 16; i++) i_mvkd_partner.key[i] = {8{$random(seed)}};
    otp = {$random(seed), $random(seed)};
    sn = {$random(seed), $random(seed), 8'h5A};
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    chk(usef, {8{8'hFF}});
    chk(cnt, 64'h0);
    chk(crdy, 1'b1);
    setc(8'h28, 8'h00, 16'hFFF3);
    cmd.data[32:63] = dig;
    vmsg(i_mvkd_partner.key[3], cmd.data[0:31]);
    run(9'h000, 1);
    setc(8'h28, 8'h20, 16'h0007);
    vmsg(i_mvkd_partner.key[7], cmd.data[0:31]);
    run(9'h001, 1);
    setc(8'h55, 8'h00, 16'h0000);
    run(9'h10F, 0);
    $display("test verify sources done");
    load(1'b1);
    setc(8'h28, 8'h01, 16'h0004);
    run(9'h10F, 0);
    load(1'b0);
    setc(8'h28, 8'h01, 16'h0004);
    cmd.data[32:63] = dig;
    vmsg(i_mvkd_partner.key[4], sval);
    run(9'h000, 1);
    chk(svalid, 1'b1);
    setc(8'h28, 8'h02, 16'h0006);
    cmd.data[32:63] = dig;
    vmsg(i_mvkd_partner.key[5], cmd.data[0:31]);
    run(9'h000, 1);
    chk(svalid, 1'b0);
    load(1'b0);
    setc(8'h28, 8'h01, 16'h0004);
    cmd.data[32:63] = dig;
    run(9'h000, 0);
    pulse_idle();
    chk(svalid, 1'b0);
    load(1'b1);
    pulse_idle();
    chk(svalid, 1'b1);
    chk(sorg, 1'b1);
    $display("test scratch copy done");
    pol[2] = 16'h2000;
    load(1'b1);
    setc(8'h1C, 8'h04, 16'h0002);
    dmsg(i_mvkd_partner.key[2]);
    run(9'h000, 1);
    chk(i_mvkd_partner.key[2], dig);
    load(1'b1);
    setc(8'h1C, 8'h00, 16'h0002);
    run(9'h10F, 0);
    load(1'b0);
    setc(8'h1C, 8'h00, 16'h0001);
    run(9'h10F, 0);
    chk(cnt, 64'h0000_0000_0001_0000);
    pol[3] = 16'h3900;
    load(1'b0);
    setc(8'h1C, 8'h00, 16'h0003);
    dmsg(i_mvkd_partner.key[9]);
    run(9'h000, 1);
    $display("test derive roll and create done");
    pol[4] = 16'hAA00;
    load(1'b0);
    setc(8'h1C, 8'h00, 16'h0004);
    cmd.data[0:31] = dig;
    hdr(i_mvkd_partner.key[10]);
    dmsg(i_mvkd_partner.key[4]);
    run(9'h000, 1);
    load(1'b0);
    setc(8'h1C, 8'h00, 16'h0004);
    cmd.data[0:31] = ~dig;
    run(9'h10F, 0);
    chk(cnt[4], 8'h01);
    $display("test derive mac done");
    pol[7] = 16'h2000;
    for (int i = 0; i < 256; i++) begin
      load(1'b0);
      setc(8'h1C, 8'h00, 16'h0007);
      run(9'h000, 0);
      if (i == 254) chk(cnt[7], 8'hFF);
    end
    chk(cnt[7], 8'h00);
    chk(usef[7], 8'hFF);
    $display("test counter wrap done");
    wrap_up();
  end
endmodule : testbench
